/* File: rtl/hdtf_pkg.sv */
// Purpose: shared constants, types and helpers of the track formatter
// Assumes: byte-serial channel on the controller clock
// Notes: lengths are in bytes
// Behaviour
// - no index mark, first gap then id mark
// - four-byte ecc guards every data field
// - id address mark is two bytes
// - id record is exactly three bytes
// - data field mark is two bytes
// - id byte holds cylinder bits seven to zero
// - id field holds cylinder bits nine, eight
// - overflow flag is cylinder bit10 or head bit3
// - id field holds head bits two to zero
// - disk size code 256,512,1024,128 as 00..11
// - track type normal, alternate, defective; 11 reserved
// - host size code translated before disk access
// - first and third gaps are fill bytes then sync field
// - fourth gap: turn-off byte, gap, twelve sync
// - gap four and five lengths not checked
package hdtf_pkg;
  localparam logic [7:0] MARK_LEAD = 8'ha1;
  localparam logic [7:0] IAM_TAIL = 8'hfe;
  localparam logic [7:0] DAM_TAIL = 8'hf8;
  localparam logic [7:0] GAP_FILL = 8'h4e;
  localparam logic [7:0] SYNC_BYTE = 8'h00;
  localparam logic [7:0] WTO_BYTE = 8'hff;
  localparam logic [10:0] MARK_LEN = 11'h002;
  localparam logic [10:0] ID_LEN = 11'h003;
  localparam logic [10:0] ECC_LEN = 11'h004;
  localparam logic [10:0] G1_GAP = 11'h004;
  localparam logic [10:0] G1_SYNC = 11'h00c;
  localparam logic [10:0] G3_GAP = 11'h003;
  localparam logic [10:0] G3_SYNC = 11'h008;
  localparam logic [10:0] G4_WTO = 11'h001;
  localparam logic [10:0] G4_SYNC = 11'h00c;
  localparam logic [10:0] CNT_RST = 11'h000;
  localparam logic [1:0] DSK_256 = 2'h0;
  localparam logic [1:0] DSK_512 = 2'h1;
  localparam logic [1:0] DSK_1024 = 2'h2;
  localparam logic [1:0] DSK_128 = 2'h3;
  localparam logic [1:0] HST_128 = 2'h0;
  localparam logic [1:0] HST_256 = 2'h1;
  localparam logic [1:0] HST_512 = 2'h2;
  localparam logic [1:0] HST_1024 = 2'h3;
  localparam logic [1:0] TRK_NORMAL = 2'h0;
  localparam logic [1:0] TRK_ALT = 2'h1;
  localparam logic [1:0] TRK_DEFECT = 2'h2;
  localparam logic [1:0] TRK_RSVD = 2'h3;
  // second id byte: cyl[9:8] at 7:6, overflow at 5, head[2:0] at 2:0
  localparam int ID1_CYL_LSB = 6;
  localparam int ID1_OVF_BIT = 5;
  localparam int ID2_SIZE_LSB = 6;
  localparam int ID2_TYPE_LSB = 4;
  localparam logic [31:0] ECC_POLY = 32'h04c11db7;
  localparam logic [31:0] ECC_INIT = 32'h00000000;
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 4;
  typedef enum logic [3:0] {
    W_IDLE, W_G1, W_IAM, W_ID, W_G3, W_DAM, W_DATA, W_ECC, W_G4
  } hdtf_wst_e;
  typedef enum logic [2:0] {
    R_HUNT, R_ID, R_DHUNT, R_DATA, R_ECC
  } hdtf_rst_e;
  function automatic logic [1:0] host_to_disk(input logic [1:0] h);
    unique case (h)
      HST_128: host_to_disk = DSK_128;
      HST_256: host_to_disk = DSK_256;
      HST_512: host_to_disk = DSK_512;
      HST_1024: host_to_disk = DSK_1024;
    endcase
  endfunction
  function automatic logic [1:0] disk_to_host(input logic [1:0] d);
    unique case (d)
      DSK_128: disk_to_host = HST_128;
      DSK_256: disk_to_host = HST_256;
      DSK_512: disk_to_host = HST_512;
      DSK_1024: disk_to_host = HST_1024;
    endcase
  endfunction
  function automatic logic [10:0] sect_len(input logic [1:0] d);
    unique case (d)
      DSK_128: sect_len = 11'h080;
      DSK_256: sect_len = 11'h100;
      DSK_512: sect_len = 11'h200;
      DSK_1024: sect_len = 11'h400;
    endcase
  endfunction
  function automatic logic [10:0] g4_gap(input logic [1:0] d);
    unique case (d)
      DSK_128: g4_gap = 11'h01a;
      DSK_256: g4_gap = 11'h028;
      DSK_512: g4_gap = 11'h038;
      DSK_1024: g4_gap = 11'h03d;
    endcase
  endfunction
endpackage

/* File: rtl/hdtf_fifo.sv */
// Purpose: small valid/ready buffer for sector data
// Assumes: single clock, synchronous active-high reset
// Notes: no bypass, a word spends at least one cycle inside
`timescale 1ns/1ps
module hdtf_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0] cnt_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (cnt_q != (AW+1)'(D));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rp_q];
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == AW'(D-1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(D-1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

/* File: rtl/hdtf_ecc.sv */
// Purpose: byte-wide 32-bit check code generator and checker
// Assumes: bytes enter msb first
// Notes: code bytes appended msb first leave a zero remainder
`timescale 1ns/1ps
module hdtf_ecc (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clr,
  input wire logic en,
  input wire logic [7:0] din,
  output logic [31:0] code
);
  logic [31:0] code_q;
  logic [31:0] step [9];
  assign step[0] = code_q;
  for (genvar i = 0; i < 8; i++) begin : g_bit
    wire fb = step[i][31] ^ din[7-i];
    assign step[i+1] = {step[i][30:0], 1'b0} ^ (fb ? hdtf_pkg::ECC_POLY : '0);
  end
  assign code = code_q;
  always_ff @(posedge clk) begin
    if (sys_rst || clr) begin
      code_q <= hdtf_pkg::ECC_INIT;
    end else if (en) begin
      code_q <= step[8];
    end
  end
endmodule

/* File: rtl/hdtf_formatter.sv */
// Purpose: writes and parses fixed-disk soft-sectored tracks
// Assumes: channel byte strobes come from logic on this clock
// Notes: ecc only flags errors; burst correction is left to firmware
`timescale 1ns/1ps
module hdtf_formatter (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic fmt_start,
  input wire logic [10:0] fmt_cyl,
  input wire logic [3:0] fmt_head,
  input wire logic [1:0] fmt_size,
  input wire logic [1:0] fmt_type,
  input wire logic [7:0] fmt_nsect,
  input wire logic hd_valid,
  output logic hd_ready,
  input wire logic [7:0] hd_data,
  input wire logic wr_strobe,
  output logic [7:0] wr_data,
  output logic wr_gate,
  output logic fmt_busy,
  output logic fmt_done,
  output logic fmt_underrun,
  input wire logic rd_enable,
  input wire logic rd_strobe,
  input wire logic [7:0] rd_data,
  output logic rd_id_valid,
  output logic [9:0] rd_cyl,
  output logic rd_ovf,
  output logic [2:0] rd_head,
  output logic [1:0] rd_size,
  output logic [1:0] rd_type,
  output logic [7:0] rd_byte,
  output logic rd_byte_valid,
  output logic rd_sect_done,
  output logic rd_ecc_err
);
  hdtf_pkg::hdtf_wst_e w_st_q, w_nxt;
  hdtf_pkg::hdtf_rst_e r_st_q;
  logic [10:0] w_cnt_q, r_cnt_q, w_end, r_end;
  logic [10:0] cyl_q;
  logic [3:0] head_q;
  logic [1:0] dsk_q, type_q, r_dsk_q;
  logic [7:0] left_q, prev_q, id0_q, id1_q;
  logic [7:0] wr_data_q, rd_byte_q, w_byte, id_byte, gap_byte;
  logic wr_gate_q, done_q, under_q, idv_q, rbv_q, sdone_q, eerr_q, chk_q;
  logic [9:0] rcyl_q;
  logic rovf_q;
  logic [2:0] rhead_q;
  logic [1:0] rsize_q, rtype_q;
  logic [31:0] w_code, r_code;
  logic [7:0] f_data;
  logic f_valid;

  wire w_busy = (w_st_q != hdtf_pkg::W_IDLE);
  wire w_go = w_busy && wr_strobe;
  wire w_last = (w_cnt_q == w_end);
  wire in_data = (w_st_q == hdtf_pkg::W_DATA);
  wire last_sect = (left_q <= 8'h01);
  wire [7:0] ecc_byte = w_code[{2'h3 - w_cnt_q[1:0], 3'h0} +: 8];
  wire [10:0] g4_fill_end = hdtf_pkg::G4_WTO + hdtf_pkg::g4_gap(dsk_q);

  hdtf_fifo #(.W(hdtf_pkg::FIFO_W), .D(hdtf_pkg::FIFO_D)) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(hd_valid),
    .in_ready(hd_ready),
    .in_data(hd_data),
    .out_valid(f_valid),
    .out_ready(w_go && in_data),
    .out_data(f_data)
  );

  hdtf_ecc u_wecc (
    .clk(clk),
    .sys_rst(sys_rst),
    .clr(w_st_q == hdtf_pkg::W_DAM),
    .en(w_go && in_data),
    .din(w_byte),
    .code(w_code)
  );

  assign w_end =
    (w_st_q == hdtf_pkg::W_G1) ? hdtf_pkg::G1_GAP + hdtf_pkg::G1_SYNC - 11'h001 :
    (w_st_q == hdtf_pkg::W_IAM) ? hdtf_pkg::MARK_LEN - 11'h001 :
    (w_st_q == hdtf_pkg::W_ID) ? hdtf_pkg::ID_LEN - 11'h001 :
    (w_st_q == hdtf_pkg::W_G3) ? hdtf_pkg::G3_GAP + hdtf_pkg::G3_SYNC - 11'h001 :
    (w_st_q == hdtf_pkg::W_DAM) ? hdtf_pkg::MARK_LEN - 11'h001 :
    in_data ? hdtf_pkg::sect_len(dsk_q) - 11'h001 :
    (w_st_q == hdtf_pkg::W_ECC) ? hdtf_pkg::ECC_LEN - 11'h001 :
    (w_st_q == hdtf_pkg::W_G4) ? g4_fill_end + hdtf_pkg::G4_SYNC - 11'h001 :
    hdtf_pkg::CNT_RST;

  // no index mark between first gap and id mark
  assign w_nxt =
    (w_st_q == hdtf_pkg::W_G1) ? hdtf_pkg::W_IAM :
    (w_st_q == hdtf_pkg::W_IAM) ? hdtf_pkg::W_ID :
    (w_st_q == hdtf_pkg::W_ID) ? hdtf_pkg::W_G3 :
    (w_st_q == hdtf_pkg::W_G3) ? hdtf_pkg::W_DAM :
    (w_st_q == hdtf_pkg::W_DAM) ? hdtf_pkg::W_DATA :
    in_data ? hdtf_pkg::W_ECC :
    (w_st_q == hdtf_pkg::W_ECC) ? hdtf_pkg::W_G4 :
    (w_st_q == hdtf_pkg::W_G4 && !last_sect) ? hdtf_pkg::W_IAM :
    hdtf_pkg::W_IDLE;

  assign id_byte =
    (w_cnt_q == 11'h000) ? cyl_q[7:0] :
    (w_cnt_q == 11'h001) ?
      {cyl_q[9:8], cyl_q[10] | head_q[3], 2'h0, head_q[2:0]} :
      {dsk_q, type_q, 4'h0};

  assign gap_byte =
    (w_st_q == hdtf_pkg::W_G1) ?
      ((w_cnt_q < hdtf_pkg::G1_GAP) ? hdtf_pkg::GAP_FILL : hdtf_pkg::SYNC_BYTE) :
    (w_st_q == hdtf_pkg::W_G3) ?
      ((w_cnt_q < hdtf_pkg::G3_GAP) ? hdtf_pkg::GAP_FILL : hdtf_pkg::SYNC_BYTE) :
    (w_cnt_q < hdtf_pkg::G4_WTO) ? hdtf_pkg::WTO_BYTE :
    (w_cnt_q < g4_fill_end) ? hdtf_pkg::GAP_FILL : hdtf_pkg::SYNC_BYTE;

  // marks are lead byte then tail byte
  assign w_byte =
    (w_st_q == hdtf_pkg::W_IAM) ?
      ((w_cnt_q == 11'h000) ? hdtf_pkg::MARK_LEAD : hdtf_pkg::IAM_TAIL) :
    (w_st_q == hdtf_pkg::W_DAM) ?
      ((w_cnt_q == 11'h000) ? hdtf_pkg::MARK_LEAD : hdtf_pkg::DAM_TAIL) :
    (w_st_q == hdtf_pkg::W_ID) ? id_byte :
    in_data ? (f_valid ? f_data : hdtf_pkg::SYNC_BYTE) :
    (w_st_q == hdtf_pkg::W_ECC) ? ecc_byte : gap_byte;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      w_st_q <= hdtf_pkg::W_IDLE;
      w_cnt_q <= hdtf_pkg::CNT_RST;
    end else if (!w_busy) begin
      if (fmt_start) begin
        w_st_q <= hdtf_pkg::W_G1;
        w_cnt_q <= hdtf_pkg::CNT_RST;
      end
    end else if (wr_strobe) begin
      w_cnt_q <= w_last ? hdtf_pkg::CNT_RST : w_cnt_q + 11'h001;
      if (w_last) begin
        w_st_q <= w_nxt;
      end
    end
  end

  // size code translated once when the pass starts
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cyl_q <= 11'h000;
      head_q <= 4'h0;
      dsk_q <= hdtf_pkg::DSK_256;
      type_q <= hdtf_pkg::TRK_NORMAL;
      left_q <= 8'h00;
    end else if (!w_busy && fmt_start) begin
      cyl_q <= fmt_cyl;
      head_q <= fmt_head;
      dsk_q <= hdtf_pkg::host_to_disk(fmt_size);
      type_q <= fmt_type;
      left_q <= fmt_nsect;
    end else if (w_go && w_last && w_st_q == hdtf_pkg::W_G4) begin
      left_q <= left_q - 8'h01;
    end
  end

  // an empty buffer during data writes zeros; the sector is then bad
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_data_q <= hdtf_pkg::SYNC_BYTE;
      wr_gate_q <= 1'b0;
      done_q <= 1'b0;
      under_q <= 1'b0;
    end else begin
      if (w_go) begin
        wr_data_q <= w_byte;
      end
      wr_gate_q <= w_busy;
      done_q <= w_go && w_last && (w_nxt == hdtf_pkg::W_IDLE);
      under_q <= w_go && in_data && !f_valid;
    end
  end

  assign wr_data = wr_data_q;
  assign wr_gate = wr_gate_q;
  assign fmt_busy = wr_gate_q;
  assign fmt_done = done_q;
  assign fmt_underrun = under_q;

  // read side
  wire r_go = rd_enable && rd_strobe;
  wire lead_seen = (prev_q == hdtf_pkg::MARK_LEAD);
  wire iam_hit = r_go && lead_seen && (rd_data == hdtf_pkg::IAM_TAIL);
  wire dam_hit = r_go && lead_seen && (rd_data == hdtf_pkg::DAM_TAIL);
  wire r_last = (r_cnt_q == r_end);
  wire r_field = (r_st_q == hdtf_pkg::R_DATA) || (r_st_q == hdtf_pkg::R_ECC);
  assign r_end =
    (r_st_q == hdtf_pkg::R_ID) ? hdtf_pkg::ID_LEN - 11'h001 :
    (r_st_q == hdtf_pkg::R_DATA) ? hdtf_pkg::sect_len(r_dsk_q) - 11'h001 :
    hdtf_pkg::ECC_LEN - 11'h001;

  // check over data and code bytes
  hdtf_ecc u_recc (
    .clk(clk),
    .sys_rst(sys_rst),
    .clr(dam_hit),
    .en(r_go && r_field),
    .din(rd_data),
    .code(r_code)
  );

  // gap bytes are skipped by hunting, their count is never checked
  always_ff @(posedge clk) begin
    if (sys_rst || !rd_enable) begin
      r_st_q <= hdtf_pkg::R_HUNT;
      r_cnt_q <= hdtf_pkg::CNT_RST;
      prev_q <= hdtf_pkg::SYNC_BYTE;
    end else if (rd_strobe) begin
      // a hit consumes the lead so mark bytes are never shared
      prev_q <= (iam_hit || dam_hit) ? hdtf_pkg::SYNC_BYTE : rd_data;
      r_cnt_q <= (r_field || r_st_q == hdtf_pkg::R_ID) && !r_last ?
        r_cnt_q + 11'h001 : hdtf_pkg::CNT_RST;
      unique case (r_st_q)
        hdtf_pkg::R_HUNT: begin
          if (iam_hit) begin
            r_st_q <= hdtf_pkg::R_ID;
          end
        end
        hdtf_pkg::R_ID: begin
          if (r_last) begin
            r_st_q <= hdtf_pkg::R_DHUNT;
          end
        end
        hdtf_pkg::R_DHUNT: begin
          // two-byte data mark; a new id mark restarts
          if (dam_hit) begin
            r_st_q <= hdtf_pkg::R_DATA;
          end else if (iam_hit) begin
            r_st_q <= hdtf_pkg::R_ID;
          end
        end
        hdtf_pkg::R_DATA: begin
          if (r_last) begin
            r_st_q <= hdtf_pkg::R_ECC;
          end
        end
        hdtf_pkg::R_ECC: begin
          if (r_last) begin
            r_st_q <= hdtf_pkg::R_HUNT;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      id0_q <= 8'h00;
      id1_q <= 8'h00;
      idv_q <= 1'b0;
      rcyl_q <= 10'h000;
      rovf_q <= 1'b0;
      rhead_q <= 3'h0;
      rsize_q <= hdtf_pkg::HST_128;
      rtype_q <= hdtf_pkg::TRK_NORMAL;
      r_dsk_q <= hdtf_pkg::DSK_256;
    end else begin
      idv_q <= 1'b0;
      if (r_go && r_st_q == hdtf_pkg::R_ID) begin
        if (r_cnt_q == 11'h000) begin
          id0_q <= rd_data;
        end
        if (r_cnt_q == 11'h001) begin
          id1_q <= rd_data;
        end
        if (r_last) begin
          idv_q <= 1'b1;
          rcyl_q <= {id1_q[hdtf_pkg::ID1_CYL_LSB +: 2], id0_q};
          rovf_q <= id1_q[hdtf_pkg::ID1_OVF_BIT];
          rhead_q <= id1_q[2:0];
          r_dsk_q <= rd_data[hdtf_pkg::ID2_SIZE_LSB +: 2];
          // host sees its own size encoding
          rsize_q <= hdtf_pkg::disk_to_host(rd_data[hdtf_pkg::ID2_SIZE_LSB +: 2]);
          rtype_q <= rd_data[hdtf_pkg::ID2_TYPE_LSB +: 2];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_byte_q <= 8'h00;
      rbv_q <= 1'b0;
      chk_q <= 1'b0;
      sdone_q <= 1'b0;
      eerr_q <= 1'b0;
    end else begin
      rbv_q <= r_go && (r_st_q == hdtf_pkg::R_DATA);
      if (r_go && r_st_q == hdtf_pkg::R_DATA) begin
        rd_byte_q <= rd_data;
      end
      chk_q <= r_go && (r_st_q == hdtf_pkg::R_ECC) && r_last;
      sdone_q <= chk_q;
      eerr_q <= chk_q && (r_code != 32'h00000000);
    end
  end

  assign rd_id_valid = idv_q;
  assign rd_cyl = rcyl_q;
  assign rd_ovf = rovf_q;
  assign rd_head = rhead_q;
  assign rd_size = rsize_q;
  assign rd_type = rtype_q;
  assign rd_byte = rd_byte_q;
  assign rd_byte_valid = rbv_q;
  assign rd_sect_done = sdone_q;
  assign rd_ecc_err = eerr_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire wg = w_go;
  a_g1_to_iam: assert property (
    (wg && w_st_q == hdtf_pkg::W_G1 && w_cnt_q == 11'h00f)
    |=> (w_st_q == hdtf_pkg::W_IAM && wr_data_q == hdtf_pkg::SYNC_BYTE))
    else $error("first gap not followed by id mark");
  a_ecc_four: assert property (
    (wg && w_st_q == hdtf_pkg::W_ECC && w_cnt_q == 11'h003)
    |=> w_st_q == hdtf_pkg::W_G4) else $error("code field not four bytes");
  a_iam_pair: assert property (
    (wg && w_st_q == hdtf_pkg::W_IAM && w_cnt_q == 11'h000)
    |=> (wr_data_q == 8'ha1 && w_st_q == hdtf_pkg::W_IAM))
    else $error("id mark broken");
  a_iam_tail: assert property (
    (wg && w_st_q == hdtf_pkg::W_IAM && w_cnt_q == 11'h001)
    |=> (wr_data_q == 8'hfe && w_st_q == hdtf_pkg::W_ID))
    else $error("id mark tail broken");
  a_id_three: assert property (
    (wg && w_st_q == hdtf_pkg::W_ID && w_cnt_q == 11'h002)
    |=> w_st_q == hdtf_pkg::W_G3) else $error("id record not three bytes");
  a_dam_tail: assert property (
    (wg && w_st_q == hdtf_pkg::W_DAM && w_cnt_q == 11'h001)
    |=> (wr_data_q == 8'hf8 && w_st_q == hdtf_pkg::W_DATA))
    else $error("data mark broken");
  a_id_cyl_low: assert property (
    (wg && w_st_q == hdtf_pkg::W_ID && w_cnt_q == 11'h000)
    |=> wr_data_q == cyl_q[7:0]) else $error("low cylinder byte wrong");
  a_id_ovf: assert property (
    (wg && w_st_q == hdtf_pkg::W_ID && w_cnt_q == 11'h001)
    |=> wr_data_q[5] == (cyl_q[10] || head_q[3]))
    else $error("overflow flag wrong");
  a_gap3_fill: assert property (
    (wg && w_st_q == hdtf_pkg::W_G3 && w_cnt_q < 11'h003)
    |=> wr_data_q == 8'h4e) else $error("third gap fill wrong");
  a_g4_turnoff: assert property (
    (wg && w_st_q == hdtf_pkg::W_G4 && w_cnt_q == 11'h000)
    |=> wr_data_q == 8'hff) else $error("turn-off byte missing");
  a_rd_id_pulse: assert property (
    rd_id_valid |-> $past(r_st_q) == hdtf_pkg::R_ID && $past(r_go))
    else $error("id pulse without record");
  c_fmt_done: cover property (fmt_done);
  c_rd_id: cover property (rd_id_valid && rd_ovf);
  c_rd_good: cover property (rd_sect_done && !rd_ecc_err);
endmodule

/* File: verification/hdtf_drive_model.sv */
// Purpose: drive data channel model, write byte slots and read playback
// Assumes: same clock as the formatter, byte-serial channel
// Notes: between read bytes the data line toggles, it never holds
`timescale 1ns/1ps
module hdtf_drive_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wr_gate,
  input wire logic [7:0] wr_data,
  input wire logic slow,
  output logic wr_strobe,
  output logic rd_strobe,
  output logic [7:0] rd_data
);
  logic [7:0] cap[$];
  logic [7:0] rd_q[$];
  logic seen;
  int cnt;
  initial begin
    wr_strobe = 1'b0;
    rd_strobe = 1'b0;
    rd_data = 8'h00;
    seen = 1'b0;
    cnt = 0;
  end
  // a byte shows in the cycle after its slot, while the gate is up
  always @(posedge clk) begin
    if (seen && wr_gate) cap.push_back(wr_data);
    seen = wr_strobe && wr_gate;
    #1;
    wr_strobe = wr_gate && !sys_rst && (!slow || (cnt % 3 == 0));
    cnt++;
  end
  task automatic play(input int gap);
    logic [7:0] b;
    while (rd_q.size() > 0) begin
      b = rd_q.pop_front();
      @(posedge clk);
      #1;
      rd_strobe = 1'b1;
      rd_data = b;
      repeat (gap) begin
        @(posedge clk);
        #1;
        rd_strobe = 1'b0;
        rd_data = ~rd_data;
      end
    end
    @(posedge clk);
    #1;
    rd_strobe = 1'b0;
  endtask
endmodule

/* File: verification/tb_hard_disk_track_formatter.sv */
// Purpose: self-checking bench for the track formatter
// Assumes: drive model gives byte slots and plays tracks back
// Notes: read side is fed the captured track, so both paths meet
`timescale 1ns/1ps
module tb_hard_disk_track_formatter;
  logic clk = 1'b0, sys_rst = 1'b1, fmt_start = 1'b0, slow = 1'b0;
  logic [10:0] fmt_cyl = 11'h000;
  logic [3:0] fmt_head = 4'h0;
  logic [1:0] fmt_size = 2'h0, fmt_type = 2'h0;
  logic [7:0] fmt_nsect = 8'h00, hd_data = 8'h00, wr_data, rd_data, rd_byte;
  logic hd_valid = 1'b0, hd_ready, wr_strobe, wr_gate, fmt_busy, fmt_done;
  logic fmt_underrun, rd_enable = 1'b0, rd_strobe, rd_id_valid, rd_ovf;
  logic [9:0] rd_cyl;
  logic [2:0] rd_head;
  logic [1:0] rd_size, rd_type;
  logic rd_byte_valid, rd_sect_done, rd_ecc_err, exp_err, fire;
  logic [17:0] exp_id;
  logic [7:0] exp[$], dq[$], dall[$], got[$];
  int errors = 0, checks = 0, seed = 22109, ids = 0, dones = 0;
  int g4[4] = '{26, 40, 56, 61};
  always #12.5 clk = ~clk;
  hdtf_formatter uut (.clk(clk), .sys_rst(sys_rst), .fmt_start(fmt_start),
    .fmt_cyl(fmt_cyl), .fmt_head(fmt_head), .fmt_size(fmt_size),
    .fmt_type(fmt_type), .fmt_nsect(fmt_nsect), .hd_valid(hd_valid),
    .hd_ready(hd_ready), .hd_data(hd_data), .wr_strobe(wr_strobe),
    .wr_data(wr_data), .wr_gate(wr_gate), .fmt_busy(fmt_busy),
    .fmt_done(fmt_done), .fmt_underrun(fmt_underrun),
    .rd_enable(rd_enable), .rd_strobe(rd_strobe), .rd_data(rd_data),
    .rd_id_valid(rd_id_valid), .rd_cyl(rd_cyl), .rd_ovf(rd_ovf),
    .rd_head(rd_head), .rd_size(rd_size), .rd_type(rd_type),
    .rd_byte(rd_byte), .rd_byte_valid(rd_byte_valid),
    .rd_sect_done(rd_sect_done), .rd_ecc_err(rd_ecc_err));
  hdtf_drive_model drv (.clk(clk), .sys_rst(sys_rst), .wr_gate(wr_gate),
    .wr_data(wr_data), .slow(slow), .wr_strobe(wr_strobe),
    .rd_strobe(rd_strobe), .rd_data(rd_data));
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] a, input logic [31:0] b);
    checks++;
    if (a !== b) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, a, b);
    end
  endtask
  task automatic put(input logic [7:0] v, input int n);
    repeat (n) exp.push_back(v);
  endtask
  // host data feeder, refused words stay at the head of the queue
  always @(posedge clk) begin
    fire = hd_valid && hd_ready;
    #1;
    if (fire) void'(dq.pop_front());
    hd_valid = dq.size() > 0;
    hd_data = (dq.size() > 0) ? dq[0] : 8'h00;
  end
  always @(posedge clk) begin
    if (rd_id_valid === 1'b1) begin
      ids++;
      check({rd_cyl, rd_ovf, rd_head, rd_size, rd_type}, exp_id);
    end
    if (rd_byte_valid === 1'b1) got.push_back(rd_byte);
    if (rd_sect_done === 1'b1) begin
      dones++;
      check(rd_ecc_err, exp_err);
    end
  end
  task automatic build(input logic [10:0] cy, input logic [3:0] hd,
      input int h, input logic [1:0] ty, input int n);
    logic [31:0] c;
    logic [7:0] b;
    exp.delete();
    dall.delete();
    put(8'h4e, 4);
    put(8'h00, 12);
    for (int s = 0; s < n; s++) begin
      exp.push_back(8'ha1);
      exp.push_back(8'hfe);
      exp.push_back(cy[7:0]);
      exp.push_back({cy[9:8], cy[10] | hd[3], 2'b00, hd[2:0]});
      exp.push_back({2'((h + 3) % 4), ty, 4'h0});
      put(8'h4e, 3);
      put(8'h00, 8);
      exp.push_back(8'ha1);
      exp.push_back(8'hf8);
      c = 32'h00000000;
      for (int i = 0; i < (128 << h); i++) begin
        b = 8'($random(seed));
        dq.push_back(b);
        dall.push_back(b);
        exp.push_back(b);
        c = c ^ {b, 24'h000000};
        for (int k = 0; k < 8; k++)
          c = c[31] ? ((c << 1) ^ hdtf_pkg::ECC_POLY) : (c << 1);
      end
      for (int k = 3; k >= 0; k--) exp.push_back(c[8*k +: 8]);
      put(8'hff, 1);
      put(8'h4e, g4[h]);
      put(8'h00, 12);
    end
  endtask
  task automatic wait_done;
    int i;
    i = 0;
    while (fmt_done !== 1'b1 && i < 20000) begin
      @(posedge clk);
      i++;
    end
    if (i >= 20000) begin
      check(32'h0, 32'h1);
      report_and_stop();
    end
  endtask
  task automatic replay(input int gap, input int flip);
    rd_enable = 1'b0;
    @(posedge clk);
    #1;
    rd_enable = 1'b1;
    got.delete();
    ids = 0;
    dones = 0;
    // longer lead-in gap must be harmless
    drv.rd_q = {8'h4e, 8'h4e, 8'h4e, drv.cap};
    if (flip > 0) drv.rd_q[flip] = ~drv.rd_q[flip];
    drv.play(gap);
    repeat (4) @(posedge clk);
  endtask
  initial begin
    logic [10:0] cy;
    logic [3:0] hd;
    logic [1:0] ty;
    int n;
    repeat (4) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    for (int t = 0; t < 4; t++) begin
      cy = 11'($random(seed));
      hd = 4'($random(seed));
      ty = 2'(t % 3);
      n = (t == 0) ? 2 : 1;
      slow = t[0];
      build(cy, hd, t, ty, n);
      repeat (6) @(posedge clk);
      check(hd_ready, 1'b0);
      drv.cap.delete();
      #1;
      fmt_start = 1'b1;
      {fmt_cyl, fmt_head, fmt_size, fmt_type} = {cy, hd, 2'(t), ty};
      fmt_nsect = 8'(n);
      @(posedge clk);
      #1;
      fmt_start = 1'b0;
      // gate is registered, it rises one cycle after the start is taken
      @(posedge clk);
      #1;
      check(wr_gate, 1'b1);
      repeat (40) @(posedge clk);
      #1;
      fmt_start = 1'b1;
      fmt_nsect = 8'h05;
      @(posedge clk);
      #1;
      fmt_start = 1'b0;
      wait_done();
      repeat (3) @(posedge clk);
      check(wr_gate, 1'b0);
      check(drv.cap.size(), exp.size());
      foreach (exp[i]) if (i < drv.cap.size()) check(drv.cap[i], exp[i]);
      exp_id = {cy[9:0], cy[10] | hd[3], hd[2:0], 2'(t), ty};
      exp_err = 1'b0;
      replay(t % 2, 0);
      check(ids, n);
      check(dones, n);
      check(got.size(), dall.size());
      foreach (dall[i]) if (i < got.size()) check(got[i], dall[i]);
      $display("test track %0d done", t);
    end
    exp_err = 1'b1;
    replay(0, 40);
    check(dones, 1);
    $display("test corrupt data done");
    report_and_stop();
  end
endmodule
